//--- hw/dsk_defs.vh
/*
 * constants of the disk seek and sector control block.
 * assumes 12-bit processor words; bit n of a command, maintenance
 * or header word is word bit [11-n], bit 0 being the msb.
 */
`ifndef DSK_DEFS_VH
`define DSK_DEFS_VH

// ----------------------------------------
// instruction codes (octal 67xx)
// ----------------------------------------
`define DSK_IO_LDA 12'hdd9
`define DSK_IO_LDC 12'hdda
`define DSK_IO_LDR 12'hddb
`define DSK_IO_RDA 12'hddc
`define DSK_IO_LDW 12'hddd
`define DSK_IO_RDC 12'hdde
`define DSK_IO_CHP 12'hddf
`define DSK_IO_RDS 12'hde1
`define DSK_IO_CLS 12'hde2
`define DSK_IO_MNT 12'hde3
`define DSK_IO_SKD 12'hde5
`define DSK_IO_SKE 12'hde7
`define DSK_IO_CLA 12'hde9

// ----------------------------------------
// field positions
// ----------------------------------------
`define DSK_CMD_SEEK 7
`define DSK_CMD_HDR 6
`define DSK_MNT_TGT 11
`define DSK_MNT_D2S 10
`define DSK_MNT_S2D 9
`define DSK_MNT_RDD 8
`define DSK_MNT_SH1 7
`define DSK_MNT_SH0 6
`define DSK_H2_BAD_HI 10
`define DSK_H2_BAD_LO 6
`define DSK_ST_DONE 0
`define DSK_ST_BUSY 1
`define DSK_ST_TRK 2
`define DSK_ST_TMO 3
`define DSK_ST_BAD 4
`define DSK_ST_PAR 5
`define DSK_ST_RATE 6

// ----------------------------------------
// timing
// ----------------------------------------
`define DSK_TMO_REVS 56
`define DSK_RATE_WORDS 4096
`define DSK_RATE_TIME_MS 40
`define DSK_CLK_MHZ 100
`define DSK_WORD_CYC ((`DSK_RATE_TIME_MS * 1000 * `DSK_CLK_MHZ) / `DSK_RATE_WORDS)

`endif

//--- hw/dsk_buf2.v
/*
 * two-entry word buffer with valid and ready on both sides.
 * assumes one clock; ready and valid come straight from flops.
 */
`timescale 1ns/1ps
module dsk_buf2 #(
	parameter W = 12
) (
	// clock and reset
	input wire clk_sys,
	input wire sys_rst,
	// filling side
	input wire in_valid,
	input wire [W-1:0] in_data,
	output reg in_ready,
	// draining side
	output reg out_valid,
	output reg [W-1:0] out_data,
	input wire out_ready
);
	reg [W-1:0] m1_r;
	reg [1:0] cnt_r;
	reg [1:0] cnt_nxt;
	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;

	always @* begin
		cnt_nxt = cnt_r;
		if (push & ~pop)
			cnt_nxt = cnt_r + 2'h1;
		else if (pop & ~push)
			cnt_nxt = cnt_r - 2'h1;
	end

	always @(posedge clk_sys) begin
		if (sys_rst) begin
			cnt_r <= 2'h0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
			out_data <= {W{1'b0}};
			m1_r <= {W{1'b0}};
		end else begin
			cnt_r <= cnt_nxt;
			in_ready <= (cnt_nxt != 2'h2);
			out_valid <= (cnt_nxt != 2'h0);
			if (pop)
				out_data <= m1_r;
			if (push) begin
				if (cnt_r == 2'h0 || (cnt_r == 2'h1 && pop))
					out_data <= in_data;
				else
					m1_r <= in_data;
			end
		end
	end
endmodule // dsk_buf2

//--- hw/dsk_shreg.v
/*
 * serial shift register of the read/write channel.
 * assumes load and shift are never requested in one cycle; load wins.
 */
`timescale 1ns/1ps
module dsk_shreg #(
	parameter W = 12
) (
	// clock and reset
	input wire clk_sys,
	input wire sys_rst,
	// control
	input wire ld,
	input wire [W-1:0] ld_val,
	input wire sh,
	input wire sh_bit,
	// contents
	output reg [W-1:0] q
);
	always @(posedge clk_sys) begin
		if (sys_rst)
			q <= {W{1'b0}};
		else if (ld)
			q <= ld_val;
		else if (sh)
			q <= {q[W-2:0], sh_bit};
	end
endmodule // dsk_shreg

//--- hw/dsk_ctrl.v
/*
 * disk seek, header check and sector search control with the
 * processor instruction decoder and the maintenance register.
 * assumes instruction, header and word strobes are synchronous
 * one-cycle pulses; index_pulse marks one revolution.
 */
`timescale 1ns/1ps
`include "dsk_defs.vh"

// Behaviour
// - sustain 4096 words per 40 ms on sequential sectors
// - loading track target steps counter and positioner until equal
// - first header track field mismatch raises track error, ends operation
// - sector target holds sector number plus one surface bit
// - each header sector field compared; match transfers, else next sector
// - sector not found in 56 revolutions sets timeout error
// - first selection without header access or seek-only loads counter from a header
// - code 6731 loads the disk address only, for maintenance
// - code 6732 loads command register, clears accumulator
// - read-start loads address, clears accumulator, reads if bit 4 clear
// - code 6735 loads address, clears accumulator, writes if bit 4 clear
// - code 6737 loads address, clears, checks parity without storing
// - code 6734 returns track, surface, sector counters in accumulator
// - code 6736 returns command register in cleared accumulator
// - code 6741 returns status register in cleared accumulator
// - code 6742 clears the done and error bits of the status register; busy holds
// - code 6743 loads maintenance register; bits hold until zero load
// - maintenance bits 0,1,2 copy targets, data to serial, serial to data
// - maintenance bit 3 reads data register; bits 4,5 shift one, zero
// - code 6745 skips when transfer-complete flag set
// - code 6747 skips when summary error flag set
// - pending error refuses read, write, seek; busy stays 0, done set
// - second header bits 1-5 set ends transfer, sets bad-sector flag; the code skips this check while command bit 5 is set
// - command bit 4 seeks only; clear seeks sector and transfers
module dsk_ctrl #(
	parameter STEP_CYC = 16
) (
	// clock and reset
	input wire clk_sys,
	input wire sys_rst,
	// processor instruction port
	input wire iot_valid,
	input wire [11:0] iot_code,
	input wire [11:0] ac_in,
	output reg ac_clear_r,
	output reg ac_load_r,
	output reg [11:0] ac_out_r,
	output reg skip_r,
	// drive positioner and selection
	input wire [1:0] drive_sel,
	output reg step_r,
	output reg step_out_r,
	// drive read channel
	input wire index_pulse,
	input wire sector_pulse,
	input wire hdr_valid,
	input wire [11:0] hdr_w1,
	input wire [11:0] hdr_w2,
	input wire rd_valid,
	input wire [11:0] rd_word,
	input wire rd_par_ok,
	output wire rd_ready,
	output reg wr_gate_r,
	// memory side of the read buffer
	output wire mem_valid,
	output wire [11:0] mem_data,
	input wire mem_ready,
	// state
	output reg busy_r
);
	// ----------------------------------------
	// states
	// ----------------------------------------
	localparam S_IDLE = 3'h0;
	localparam S_TRKLD = 3'h1;
	localparam S_STEP = 3'h2;
	localparam S_VERIFY = 3'h3;
	localparam S_SEARCH = 3'h4;
	localparam S_XFER = 3'h5;
	localparam [7:0] STEP_GAP = STEP_CYC[7:0];
	localparam [5:0] TMO_LAST = `DSK_TMO_REVS - 1;

	reg [2:0] st_r;
	reg [11:0] cmd_r;
	reg [11:0] mnt_r;
	reg [11:0] dreg_r;
	reg [6:0] trk_tgt_r;
	reg [4:0] sec_tgt_r;
	reg [6:0] trk_cnt_r;
	reg [4:0] sec_cnt_r;
	reg [7:0] gap_r;
	reg [5:0] rev_r;
	reg seek_only_r;
	reg write_r;
	reg check_r;
	reg new_sel_r;
	reg [1:0] sel_q_r;
	reg done_r;
	reg trk_err_r;
	reg tmo_err_r;
	reg bad_err_r;
	reg par_err_r;
	reg rate_err_r;

	wire err_any = trk_err_r | tmo_err_r | bad_err_r | par_err_r | rate_err_r;
	wire [11:0] status = {5'h00, rate_err_r, par_err_r, bad_err_r,
		tmo_err_r, trk_err_r, busy_r, done_r};
	wire [11:0] ser_q;

	// ----------------------------------------
	// instruction decode
	// ----------------------------------------
	wire io_lda = iot_valid & (iot_code == `DSK_IO_LDA);
	wire io_ldc = iot_valid & (iot_code == `DSK_IO_LDC);
	wire io_ldr = iot_valid & (iot_code == `DSK_IO_LDR);
	wire io_ldw = iot_valid & (iot_code == `DSK_IO_LDW);
	wire io_chp = iot_valid & (iot_code == `DSK_IO_CHP);
	wire io_rda = iot_valid & (iot_code == `DSK_IO_RDA);
	wire io_rdc = iot_valid & (iot_code == `DSK_IO_RDC);
	wire io_rds = iot_valid & (iot_code == `DSK_IO_RDS);
	wire io_cls = iot_valid & (iot_code == `DSK_IO_CLS);
	wire io_mnt = iot_valid & (iot_code == `DSK_IO_MNT);
	wire io_skd = iot_valid & (iot_code == `DSK_IO_SKD);
	wire io_ske = iot_valid & (iot_code == `DSK_IO_SKE);
	wire io_cla = iot_valid & (iot_code == `DSK_IO_CLA);
	wire io_start = io_ldr | io_ldw | io_chp;

	// header fields: track, then surface and sector
	wire [6:0] h_trk = hdr_w1[11:5];
	wire [4:0] h_sec = hdr_w1[4:0];
	wire h_bad = |hdr_w2[`DSK_H2_BAD_HI:`DSK_H2_BAD_LO];
	wire hdr_chk = hdr_valid & (st_r == S_VERIFY || st_r == S_SEARCH);

	// ----------------------------------------
	// maintenance side effects
	// ----------------------------------------
	wire m_d2s = io_mnt & ac_in[`DSK_MNT_D2S];
	wire m_sh = io_mnt & (ac_in[`DSK_MNT_SH1] | ac_in[`DSK_MNT_SH0]);

	dsk_shreg #(
		.W(12)
	) u_ser (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.ld(m_d2s),
		.ld_val(dreg_r),
		.sh(m_sh),
		.sh_bit(ac_in[`DSK_MNT_SH1]),
		.q(ser_q)
	);

	// ----------------------------------------
	// read word buffer
	// ----------------------------------------
	// parity-check reads are not stored, so only normal reads push.
	// the channel cannot wait; a full buffer counts as a rate error.
	wire push_ok = (st_r == S_XFER) & ~write_r & ~check_r;
	wire buf_in_valid = rd_valid & push_ok;

	dsk_buf2 #(
		.W(12)
	) u_buf (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.in_valid(buf_in_valid),
		.in_data(rd_word),
		.in_ready(rd_ready),
		.out_valid(mem_valid),
		.out_data(mem_data),
		.out_ready(mem_ready)
	);

	// ----------------------------------------
	// processor answers
	// ----------------------------------------
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			ac_clear_r <= 1'b0;
			ac_load_r <= 1'b0;
			ac_out_r <= 12'h000;
			skip_r <= 1'b0;
		end else begin
			ac_clear_r <= io_ldc | io_start | io_rda | io_rdc | io_rds
				| (io_mnt & ac_in[`DSK_MNT_RDD]);
			ac_load_r <= io_rda | io_rdc | io_rds
				| (io_mnt & ac_in[`DSK_MNT_RDD]);
			ac_out_r <= 12'h000;
			if (io_rda)
				ac_out_r <= {trk_cnt_r, sec_cnt_r};
			if (io_rdc)
				ac_out_r <= cmd_r;
			if (io_rds)
				ac_out_r <= status;
			if (io_mnt & ac_in[`DSK_MNT_RDD])
				ac_out_r <= dreg_r;
			skip_r <= (io_skd & done_r) | (io_ske & err_any);
		end
	end

	// ----------------------------------------
	// registers loaded by instructions
	// ----------------------------------------
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			cmd_r <= 12'h000;
			mnt_r <= 12'h000;
			dreg_r <= 12'h000;
			sel_q_r <= 2'h0;
			new_sel_r <= 1'b1;
		end else begin
			sel_q_r <= drive_sel;
			if (drive_sel != sel_q_r)
				new_sel_r <= 1'b1;
			else if (st_r == S_TRKLD && hdr_valid)
				new_sel_r <= 1'b0;
			if (io_ldc)
				cmd_r <= ac_in;
			if (io_mnt)
				mnt_r <= ac_in;
			if (io_mnt & ac_in[`DSK_MNT_S2D])
				dreg_r <= ser_q;
			if (io_cla) begin
				cmd_r <= 12'h000;
				mnt_r <= 12'h000;
				dreg_r <= 12'h000;
			end
		end
	end

	// ----------------------------------------
	// seek, header check and sector search
	// ----------------------------------------
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			st_r <= S_IDLE;
			trk_tgt_r <= 7'h00;
			sec_tgt_r <= 5'h00;
			trk_cnt_r <= 7'h00;
			sec_cnt_r <= 5'h00;
			gap_r <= 8'h00;
			rev_r <= 6'h00;
			seek_only_r <= 1'b0;
			write_r <= 1'b0;
			check_r <= 1'b0;
			busy_r <= 1'b0;
			step_r <= 1'b0;
			step_out_r <= 1'b0;
			wr_gate_r <= 1'b0;
			done_r <= 1'b0;
			trk_err_r <= 1'b0;
			tmo_err_r <= 1'b0;
			bad_err_r <= 1'b0;
			par_err_r <= 1'b0;
			rate_err_r <= 1'b0;
		end else begin
			step_r <= 1'b0;
			if (gap_r != 8'h00)
				gap_r <= gap_r - 8'h01;
			// the clear goes first so a flag raised this cycle survives
			if (io_cls) begin
				done_r <= 1'b0;
				trk_err_r <= 1'b0;
				tmo_err_r <= 1'b0;
				bad_err_r <= 1'b0;
				par_err_r <= 1'b0;
				rate_err_r <= 1'b0;
			end
			if (io_lda) begin
				trk_tgt_r <= ac_in[11:5];
				sec_tgt_r <= ac_in[4:0];
			end
			if (mnt_r[`DSK_MNT_TGT]) begin
				trk_cnt_r <= trk_tgt_r;
				sec_cnt_r <= sec_tgt_r;
			end
			if (io_start) begin
				trk_tgt_r <= ac_in[11:5];
				sec_tgt_r <= ac_in[4:0];
				if (err_any || busy_r) begin
					done_r <= 1'b1;
				end else begin
					busy_r <= 1'b1;
					done_r <= 1'b0;
					write_r <= io_ldw;
					check_r <= io_chp;
					seek_only_r <= cmd_r[`DSK_CMD_SEEK];
					if (new_sel_r & ~cmd_r[`DSK_CMD_HDR] & ~cmd_r[`DSK_CMD_SEEK])
						st_r <= S_TRKLD;
					else
						st_r <= S_STEP;
				end
			end
			case (st_r)
				S_IDLE: begin
					wr_gate_r <= 1'b0;
				end
				S_TRKLD: begin
					if (hdr_valid) begin
						trk_cnt_r <= h_trk;
						st_r <= S_STEP;
					end
				end
				S_STEP: begin
					rev_r <= 6'h00;
					if (trk_cnt_r == trk_tgt_r) begin
						if (seek_only_r) begin
							busy_r <= 1'b0;
							done_r <= 1'b1;
							st_r <= S_IDLE;
						end else begin
							st_r <= S_VERIFY;
						end
					end else if (gap_r == 8'h00) begin
						step_r <= 1'b1;
						step_out_r <= (trk_tgt_r < trk_cnt_r);
						gap_r <= STEP_GAP;
						if (trk_tgt_r > trk_cnt_r)
							trk_cnt_r <= trk_cnt_r + 7'h01;
						else
							trk_cnt_r <= trk_cnt_r - 7'h01;
					end
				end
				S_VERIFY, S_SEARCH: begin
					if (index_pulse) begin
						rev_r <= rev_r + 6'h01;
						if (rev_r == TMO_LAST) begin
							tmo_err_r <= 1'b1;
							busy_r <= 1'b0;
							done_r <= 1'b1;
							st_r <= S_IDLE;
						end
					end
					if (hdr_chk) begin
						if (st_r == S_VERIFY && h_trk != trk_tgt_r) begin
							trk_err_r <= 1'b1;
							busy_r <= 1'b0;
							done_r <= 1'b1;
							st_r <= S_IDLE;
						end else if (h_sec == sec_tgt_r) begin
							sec_cnt_r <= h_sec;
							if (h_bad & ~cmd_r[`DSK_CMD_HDR]) begin
								bad_err_r <= 1'b1;
								busy_r <= 1'b0;
								done_r <= 1'b1;
								st_r <= S_IDLE;
							end else begin
								wr_gate_r <= write_r;
								st_r <= S_XFER;
							end
						end else begin
							st_r <= S_SEARCH;
						end
					end
				end
				S_XFER: begin
					if (rd_valid & ~write_r & ~rd_par_ok)
						par_err_r <= 1'b1;
					if (buf_in_valid & ~rd_ready)
						rate_err_r <= 1'b1;
					if (sector_pulse) begin
						wr_gate_r <= 1'b0;
						busy_r <= 1'b0;
						done_r <= 1'b1;
						st_r <= S_IDLE;
					end
				end
				default: begin
					st_r <= S_IDLE;
				end
			endcase
			// clear-all: drop flags and home the heads as a seek to track 0
			if (io_cla) begin
				trk_err_r <= 1'b0;
				tmo_err_r <= 1'b0;
				bad_err_r <= 1'b0;
				par_err_r <= 1'b0;
				rate_err_r <= 1'b0;
				done_r <= 1'b0;
				wr_gate_r <= 1'b0;
				trk_tgt_r <= 7'h00;
				sec_tgt_r <= 5'h00;
				seek_only_r <= 1'b1;
				busy_r <= 1'b1;
				st_r <= S_STEP;
			end
		end
	end
endmodule // dsk_ctrl

//--- sim/dsk_ctrl_assertions.sv
/* port assertions of the disk control block.
 assumes answers one cycle after the taking edge. */
`timescale 1ns/1ps
`include "dsk_defs.vh"
module dsk_ctrl_assertions #(
	parameter STEP_CYC = 16
) (
	// clock and reset
	input wire clk_sys,
	input wire sys_rst,
	// processor side
	input wire iot_valid,
	input wire [11:0] iot_code,
	input wire [11:0] ac_in,
	input wire ac_clear_r,
	input wire ac_load_r,
	input wire [11:0] ac_out_r,
	input wire skip_r,
	// drive and memory side
	input wire step_r,
	input wire wr_gate_r,
	input wire mem_valid,
	input wire mem_ready,
	input wire busy_r
);
	reg [11:0] cmd_r;
	reg [15:0] gap_r;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// ----------------
	// helper state
	// ----------------
	always @(posedge clk_sys) begin
		if (sys_rst || (iot_valid && iot_code == `DSK_IO_CLA))
			cmd_r <= 12'h000;
		else if (iot_valid && iot_code == `DSK_IO_LDC)
			cmd_r <= ac_in;
		if (sys_rst || step_r)
			gap_r <= 16'h0000;
		else if (gap_r != 16'hffff)
			gap_r <= gap_r + 16'h0001;
	end
	AST_LDC_CLR: assert property (iot_valid && iot_code == `DSK_IO_LDC |=> ac_clear_r && !ac_load_r)
		else $error("command load did not clear only");
	AST_RDC_VAL: assert property (iot_valid && iot_code == `DSK_IO_RDC |=> ac_load_r && ac_out_r == cmd_r)
		else $error("command readback wrong");
	AST_RDS_LOAD: assert property (iot_valid && iot_code == `DSK_IO_RDS |=> ac_clear_r && ac_load_r)
		else $error("status read missing");
	AST_CLS_QUIET: assert property (iot_valid && iot_code == `DSK_IO_CLS |=> !ac_clear_r && !ac_load_r)
		else $error("status clear touched accumulator");
	AST_SKIP_CAUSE: assert property (skip_r |-> $past(iot_valid) && ($past(iot_code) == `DSK_IO_SKD || $past(iot_code) == `DSK_IO_SKE))
		else $error("skip without flag test");
	AST_OUT_IDLE: assert property (!ac_load_r |-> ac_out_r == 12'h000)
		else $error("returned value outside load");
	AST_STEP_BUSY: assert property (step_r |-> busy_r && gap_r >= STEP_CYC)
		else $error("step while idle or too soon");
	AST_WR_BUSY: assert property (wr_gate_r |-> busy_r)
		else $error("write gate while idle");
	AST_START_CLR: assert property (iot_valid && (iot_code == `DSK_IO_LDR || iot_code == `DSK_IO_CHP) |=> ac_clear_r)
		else $error("start did not clear accumulator");
	COV_SKIP: cover property (skip_r);
	COV_STEP: cover property (step_r);
	COV_DONE: cover property ($fell(busy_r));
	COV_MEM: cover property (mem_valid && mem_ready);
endmodule // dsk_ctrl_assertions

bind dsk_ctrl dsk_ctrl_assertions #(.STEP_CYC(STEP_CYC)) u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.iot_valid(iot_valid), .iot_code(iot_code), .ac_in(ac_in), .ac_clear_r(ac_clear_r), .ac_load_r(ac_load_r),
	.ac_out_r(ac_out_r), .skip_r(skip_r), .step_r(step_r), .wr_gate_r(wr_gate_r), .mem_valid(mem_valid),
	.mem_ready(mem_ready), .busy_r(busy_r));

//--- sim/dsk_disk_model.sv
/* drive model: head position, eight sectors a revolution, headers, words.
 assumes one clock; the channel pushes words whether or not there is room. */
`timescale 1ns/1ps
module dsk_disk_model (
	// clock
	input wire clk_sys,
	// positioner
	input wire step_r,
	input wire step_out_r,
	// fault knobs
	input wire bad_trk,
	input wire bad_sec,
	input wire bad_par,
	// read channel
	output reg index_pulse,
	output reg sector_pulse,
	output reg hdr_valid,
	output reg [11:0] hdr_w1,
	output reg [11:0] hdr_w2,
	output reg rd_valid,
	output reg [11:0] rd_word,
	output reg rd_par_ok
);
	reg [5:0] cyc_r = 6'h00;
	reg [2:0] sec_r = 3'h0;
	reg [6:0] pos_r = 7'h00;
	wire [3:0] wk = cyc_r[5:2] - 4'h2;
	initial {index_pulse, sector_pulse, hdr_valid, hdr_w1, hdr_w2, rd_valid, rd_word, rd_par_ok} = 0;
	always @(posedge clk_sys) begin
		cyc_r <= (cyc_r == 6'd47) ? 6'h00 : cyc_r + 6'h01;
		if (cyc_r == 6'd47)
			sec_r <= sec_r + 3'h1;
		if (step_r)
			pos_r <= step_out_r ? pos_r - 7'h01 : pos_r + 7'h01;
		index_pulse <= cyc_r == 6'h00 && sec_r == 3'h0;
		sector_pulse <= cyc_r == 6'd40;
		hdr_valid <= cyc_r == 6'h02;
		// released lines toggle so a stale value is never mistaken for data
		hdr_w1 <= (cyc_r == 6'h02) ? {pos_r + {6'h00, bad_trk}, 2'b00, sec_r} : ~hdr_w1;
		hdr_w2 <= (cyc_r == 6'h02) ? {1'b0, {5{bad_sec}}, 6'h00} : ~hdr_w2;
		rd_valid <= cyc_r >= 6'd8 && cyc_r < 6'd40 && cyc_r[1:0] == 2'b00;
		rd_word <= (cyc_r[1:0] == 2'b00) ? {1'b0, sec_r, 5'h00, wk[2:0]} : ~rd_word;
		rd_par_ok <= !bad_par;
	end
endmodule // dsk_disk_model

//--- sim/disk_seek_sector_command_control_tb_top.sv
/* self-checking bench of the disk control block.
 assumes the drive model and the bound checker. */
`timescale 1ns/1ps
`include "dsk_defs.vh"
module disk_seek_sector_command_control_tb_top;
	reg clk_sys = 0, sys_rst = 1, iot_valid = 0, mem_ready = 0, bad_trk = 0, bad_sec = 0, stall = 0, bad_par = 0;
	reg [11:0] iot_code = 0, ac_in = 0, v, o;
	reg [6:0] tr;
	reg [2:0] s;
	reg [1:0] dsel = 0;
	reg sk, clr, wg, rlow;
	integer fails = 0, checked = 0, cycles = 0, nsteps = 0, seed = 32'h3a970d56, i, k;
	reg [11:0] got[$];
	wire ac_clear_r, ac_load_r, skip_r, step_r, step_out_r, index_pulse, sector_pulse, hdr_valid;
	wire rd_valid, rd_par_ok, rd_ready, wr_gate_r, mem_valid, busy_r;
	wire [11:0] ac_out_r, hdr_w1, hdr_w2, rd_word, mem_data;
	dsk_ctrl #(.STEP_CYC(4)) i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .iot_valid(iot_valid),
		.iot_code(iot_code), .ac_in(ac_in), .ac_clear_r(ac_clear_r), .ac_load_r(ac_load_r), .ac_out_r(ac_out_r),
		.skip_r(skip_r), .drive_sel(dsel), .step_r(step_r), .step_out_r(step_out_r), .index_pulse(index_pulse),
		.sector_pulse(sector_pulse), .hdr_valid(hdr_valid), .hdr_w1(hdr_w1), .hdr_w2(hdr_w2),
		.rd_valid(rd_valid), .rd_word(rd_word), .rd_par_ok(rd_par_ok), .rd_ready(rd_ready),
		.wr_gate_r(wr_gate_r), .mem_valid(mem_valid), .mem_data(mem_data), .mem_ready(mem_ready), .busy_r(busy_r));
	dsk_disk_model i_disk (.clk_sys(clk_sys), .step_r(step_r), .step_out_r(step_out_r), .bad_trk(bad_trk),
		.bad_sec(bad_sec), .bad_par(bad_par), .index_pulse(index_pulse), .sector_pulse(sector_pulse),
		.hdr_valid(hdr_valid),
		.hdr_w1(hdr_w1), .hdr_w2(hdr_w2), .rd_valid(rd_valid), .rd_word(rd_word), .rd_par_ok(rd_par_ok));
	initial begin
		forever #5 clk_sys = ~clk_sys;
	end
	// ----------------
	// monitors and stall source
	// ----------------
	always @(posedge clk_sys) begin
		if (step_r) nsteps = nsteps + 1;
		if (wr_gate_r) wg = 1;
		if (!rd_ready) rlow = 1;
		if (mem_valid && mem_ready) got.push_back(mem_data);
		// drains at least every other cycle, so only a forced stall fills the buffer
		mem_ready <= !stall && ((cycles & 1) || ($random(seed) & 1));
		cycles = cycles + 1;
		if (cycles == 60000) begin
			fails = fails + 1;
			close_out;
		end
	end
	task chk(input [11:0] seen, input [11:0] exp);
		begin
			checked = checked + 1;
			if (seen !== exp) begin
				fails = fails + 1;
				$display("unexpected at %0t: got %h want %h", $time, seen, exp);
			end
		end
	endtask
	task io_transfer_instruction(input [11:0] c, input [11:0] a);
		begin
			@(posedge clk_sys);
			iot_valid <= 1;
			iot_code <= c;
			ac_in <= a;
			@(posedge clk_sys);
			iot_valid <= 0;
			@(negedge clk_sys);
			o = ac_out_r;
			sk = skip_r;
			clr = ac_clear_r;
		end
	endtask
	task flag(input [11:0] c, input e);
		begin
			io_transfer_instruction(c, 12'h000);
			chk({11'h0, sk}, {11'h0, e});
		end
	endtask
	task run(input [11:0] c, input [11:0] a, input integer lim);
		begin
			got.delete();
			nsteps = 0;
			wg = 0;
			rlow = 0;
			io_transfer_instruction(c, a);
			while (busy_r === 1'b1 && lim > 0) begin
				@(negedge clk_sys);
				lim = lim - 1;
			end
			if (lim == 0) chk(12'h001, 12'h000);
		end
	endtask
	task close_out;
		begin
			$display("checked %0d fails %0d", checked, fails);
			if (fails == 0 && checked > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	initial begin
		repeat (20) @(posedge clk_sys);
		sys_rst <= 0;
		flag(`DSK_IO_SKD, 0);
		flag(`DSK_IO_SKE, 0);
		for (i = 0; i < 4; i = i + 1) begin
			v = $random(seed);
			io_transfer_instruction(`DSK_IO_LDC, v);
			chk({11'h0, clr}, 12'h001);
			io_transfer_instruction(`DSK_IO_RDC, 12'h000);
			chk(o, v);
		end
		$display("test registers done");
		tr = 3 + ($random(seed) & 7);
		io_transfer_instruction(`DSK_IO_LDC, 12'h080);
		run(`DSK_IO_LDR, {tr, 5'h00}, 3000);
		chk(nsteps, tr);
		chk(12'(got.size()), 12'h000);
		flag(`DSK_IO_SKD, 1);
		io_transfer_instruction(`DSK_IO_RDA, 12'h000);
		chk({5'h00, o[11:5]}, {5'h00, tr});
		io_transfer_instruction(`DSK_IO_CLS, 12'h000);
		flag(`DSK_IO_SKD, 0);
		$display("test seek done");
		io_transfer_instruction(`DSK_IO_LDC, 12'h000);
		s = $random(seed);
		run(`DSK_IO_LDR, {tr, 2'b00, s}, 3000);
		chk(12'(got.size()), 12'h008);
		for (k = 0; k < 8; k = k + 1)
			chk(got[k], {1'b0, s, 5'h00, 3'(k)});
		flag(`DSK_IO_SKE, 0);
		for (i = 0; i < 2; i = i + 1) begin
			io_transfer_instruction(`DSK_IO_CLS, 12'h000);
			run(i ? `DSK_IO_LDW : `DSK_IO_CHP, {tr, 5'h02}, 3000);
			chk(12'(got.size()), 12'h000);
			chk({11'h0, wg}, 12'(i));
		end
		$display("test transfers done");
		bad_sec <= 1;
		run(`DSK_IO_LDR, {tr, 5'h01}, 3000);
		flag(`DSK_IO_SKE, 1);
		bad_sec <= 0;
		io_transfer_instruction(`DSK_IO_CLS, 12'h000);
		flag(`DSK_IO_SKE, 0);
		bad_trk <= 1;
		run(`DSK_IO_LDR, {tr, 5'h01}, 3000);
		flag(`DSK_IO_SKE, 1);
		bad_trk <= 0;
		io_transfer_instruction(`DSK_IO_LDR, {tr, 5'h01});
		chk({11'h0, busy_r}, 12'h000);
		flag(`DSK_IO_SKD, 1);
		io_transfer_instruction(`DSK_IO_CLS, 12'h000);
		run(`DSK_IO_LDR, {tr, 5'h09}, 25000);
		flag(`DSK_IO_SKE, 1);
		io_transfer_instruction(`DSK_IO_CLS, 12'h000);
		bad_par <= 1;
		run(`DSK_IO_CHP, {tr, 5'h02}, 3000);
		flag(`DSK_IO_SKE, 1);
		bad_par <= 0;
		io_transfer_instruction(`DSK_IO_CLS, 12'h000);
		$display("test errors done");
		stall <= 1;
		run(`DSK_IO_LDR, {tr, 5'h03}, 3000);
		chk({11'h0, rlow}, 12'h001);
		flag(`DSK_IO_SKE, 1);
		stall <= 0;
		repeat (8) @(posedge clk_sys);
		chk(12'(got.size()), 12'h002);
		io_transfer_instruction(`DSK_IO_CLS, 12'h000);
		$display("test buffer done");
		for (k = 0; k < 2; k = k + 1) begin
			repeat (12) io_transfer_instruction(`DSK_IO_MNT, k ? 12'h040 : 12'h080);
			io_transfer_instruction(`DSK_IO_MNT, 12'h200);
			io_transfer_instruction(`DSK_IO_MNT, 12'h100);
			chk(o, k ? 12'h000 : 12'hfff);
			chk({11'h0, clr}, 12'h001);
		end
		// data register is zero here, so a load into the serial register must wipe the ones
		repeat (12) io_transfer_instruction(`DSK_IO_MNT, 12'h080);
		io_transfer_instruction(`DSK_IO_MNT, 12'h400);
		io_transfer_instruction(`DSK_IO_MNT, 12'h200);
		io_transfer_instruction(`DSK_IO_MNT, 12'h100);
		chk(o, 12'h000);
		io_transfer_instruction(`DSK_IO_LDA, {7'd20, 5'h03});
		io_transfer_instruction(`DSK_IO_MNT, 12'h800);
		io_transfer_instruction(`DSK_IO_MNT, 12'h000);
		io_transfer_instruction(`DSK_IO_RDA, 12'h000);
		chk(o, {7'd20, 5'h03});
		$display("test maintenance done");
		// counter now disagrees with the heads; a new selection must relearn it from a header
		@(posedge clk_sys);
		dsel <= 2'b01;
		run(`DSK_IO_LDR, {tr, 5'h00}, 3000);
		chk(nsteps, 12'h000);
		chk(12'(got.size()), 12'h008);
		flag(`DSK_IO_SKE, 0);
		run(`DSK_IO_CLA, 12'h000, 3000);
		chk(nsteps, tr);
		flag(`DSK_IO_SKD, 1);
		io_transfer_instruction(`DSK_IO_RDA, 12'h000);
		chk(o, 12'h000);
		$display("test selection and clear-all done");
		close_out;
	end
endmodule // disk_seek_sector_command_control_tb_top
